// ==== sim/swfc_fabric_model.sv ====
// Behavioural fabric register space that answers the indirect window.
// Assumes fab_req stays steady from valid until the edge that samples ack.
`timescale 1ns/1ps

module swfc_fabric_model
    import swfc_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire swfc_fab_req_t fab_req,
    output swfc_fab_rsp_t      fab_rsp,
    input  wire logic [3:0]    ack_delay
);
    logic [31:0] mem_q [16];
    logic [3:0]  cnt_q;

    // Read data is only meaningful with ack; otherwise it keeps toggling.
    always_ff @(posedge sys_clk) begin
        fab_rsp.ack   <= 1'b0;
        fab_rsp.rdata <= ~fab_rsp.rdata;
        if (rst) begin
            cnt_q         <= 4'h0;
            fab_rsp.rdata <= 32'h0000_0000;
        end else if (fab_req.valid && !fab_rsp.ack) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == ack_delay) begin
                cnt_q       <= 4'h0;
                fab_rsp.ack <= 1'b1;
                if (fab_req.wr) begin
                    mem_q[fab_req.index[3:0]] <= fab_req.wdata;
                end else begin
                    fab_rsp.rdata <= mem_q[fab_req.index[3:0]];
                end
            end
        end
    end
endmodule : swfc_fabric_model

// ==== sim/switch_port0_flow_ctl_and_fabric_reg_value_test.sv ====
// Self-checking bench for the port 0 flow control and fabric window slice.
// Assumes an APB slave that raises pready in its own time and a fabric model.
`timescale 1ns/1ps
`include "swfc_defines.svh"

module switch_port0_flow_ctl_and_fabric_reg_value_test
    import swfc_pkg::*;
;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0000_0000;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [2:0]    strap = 3'h0;
    logic [5:0]    ins = 6'h00;
    logic [4:0]    outs;
    logic [3:0]    ack_delay = 4'h0;
    swfc_fab_req_t fab_req;
    swfc_fab_rsp_t fab_rsp;
    int            bad_count = 0;
    int            n_compared = 0;
    logic [34:0]   exp_q [$];
    logic [34:0]   mon_e;
    logic [31:0]   rd;

    always #2.5 sys_clk = ~sys_clk;

    swfc_port0_regs swfc_port0_regs_i (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .backpressure_strap(strap[2]), .duplex_pause_strap(strap[1]),
        .manual_select_strap(strap[0]), .an_enable(ins[5]), .an_rx_pause(ins[4]),
        .an_tx_pause(ins[3]), .port_half_duplex(ins[2]), .mac_rx_fifo_high(ins[1]),
        .sw_rx_fifo_high(ins[0]), .sw_tx_hold(outs[4]), .mac_tx_hold(outs[3]),
        .backpressure_gen(outs[2]), .rx_pause_active(outs[1]), .tx_pause_active(outs[0]),
        .fab_req(fab_req), .fab_rsp(fab_rsp));

    swfc_fabric_model swfc_fabric_model_i (.sys_clk(sys_clk), .rst(rst), .fab_req(fab_req),
        .fab_rsp(fab_rsp), .ack_delay(ack_delay));

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Entry layout: check, is read, expected error, expected data.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [34:0] e);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        exp_q.push_back(e);
        @(posedge sys_clk);
        penable <= 1'b1;
        // The wait ends when pready rises; it has no limit of its own, so only the watchdog ends it if pready never comes.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {3'b100, 32'h0});
    endtask : wr

    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {3'b110, x});
    endtask : rdc

    task wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `SWFC_CMD_OFS, 32'h0, 35'h0);
            n++;
        end while (rd[31] !== 1'b0 && n < 40);
        check("busy", 32'h0, {31'h0, rd[31]});
    endtask : wait_idle

    function automatic logic [31:0] fc_exp(input logic [7:0] w, input logic [3:0] an);
        logic use_bits;
        logic rx;
        logic tx;
        use_bits = w[0] | !an[3];
        rx = (use_bits ? w[2] : an[2]) & !an[0];
        tx = (use_bits ? w[1] : an[1]) & !an[0];
        return {24'h0, w[7:6], an[0], rx, tx, w[2:0]};
    endfunction : fc_exp

    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            if (mon_e[34]) begin
                check("pslverr", {31'h0, mon_e[32]}, {31'h0, pslverr});
                if (mon_e[33]) begin
                    check("prdata", mon_e[31:0], prdata);
                end
            end
        end
    end

    initial begin
        int i;
        logic [31:0] v;
        logic [31:0] e;
        void'($urandom(99));
        strap <= 3'($urandom);
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rdc(`SWFC_FC_OFS, fc_exp({1'b0, strap[2], 3'h0, strap[1], strap[1], strap[0]}, 4'h0));
        rdc(`SWFC_DATA_OFS, `SWFC_DATA_RST);
        $display("test strap reset done");
        for (i = 0; i < 24; i++) begin
            v = $urandom & 32'hFFFF_FF7F;
            ins <= {v[11:8], 2'b00};
            wr(`SWFC_FC_OFS, v);
            repeat (3) @(posedge sys_clk);
            e = fc_exp(v[7:0], v[11:8]);
            rdc(`SWFC_FC_OFS, e);
            check("bp_gen", {31'h0, v[6] & v[8]}, {31'h0, outs[2]});
            check("pause_act", {30'h0, e[4:3]}, {30'h0, outs[1:0]});
        end
        $display("test flow config done");
        wr(`SWFC_FC_OFS, 32'h0000_0081);
        for (i = 0; i < 4; i++) begin
            ins <= {4'h0, 2'(i)};
            repeat (3) @(posedge sys_clk);
            check("fifo_hold", {30'h0, 2'(i)}, {30'h0, outs[4:3]});
        end
        wr(`SWFC_FC_OFS, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        check("fifo_hold_off", 32'h0, {30'h0, outs[4:3]});
        $display("test coupling done");
        for (i = 0; i < 2; i++) begin
            ack_delay <= (i == 0) ? 4'h0 : 4'hA;
            v = $urandom;
            wr(`SWFC_DATA_OFS, v);
            wr(`SWFC_CMD_OFS, 32'h8000_0000 | 32'(i + 3));
            wr(`SWFC_DATA_OFS, ~v);
            wait_idle;
            rdc(`SWFC_DATA_OFS, v);
            wr(`SWFC_DATA_OFS, ~v);
            wr(`SWFC_CMD_OFS, 32'hC000_0000 | 32'(i + 3));
            wait_idle;
            rdc(`SWFC_DATA_OFS, v);
            rdc(`SWFC_CMD_OFS, 32'h4000_0000 | 32'(i + 3));
        end
        $display("test fabric access done");
        apb(1'b1, 12'h1B4, 32'hFFFF_FFFF, {3'b101, 32'h0});
        apb(1'b0, 12'h1B4, 32'h0, {3'b111, 32'h0});
        $display("test unmapped done");
        report_and_stop;
    end

    initial begin
        #25000;
        bad_count++;
        report_and_stop;
    end
endmodule : switch_port0_flow_ctl_and_fabric_reg_value_test

// ==== verilog/swfc_defines.svh ====
// Offsets, field positions, reset values and counts for the port 0 flow
// control register and the indirect fabric register window.
// Assumes a 12-bit APB byte address and a 200 MHz sys_clk.
`ifndef SWFC_DEFINES_SVH
`define SWFC_DEFINES_SVH

`define SWFC_FC_OFS     12'h1A8
`define SWFC_DATA_OFS   12'h1AC
`define SWFC_CMD_OFS    12'h1B0

`define SWFC_FC_COUPLE  7
`define SWFC_FC_BP      6
`define SWFC_FC_DUP     5
`define SWFC_FC_CRX     4
`define SWFC_FC_CTX     3
`define SWFC_FC_RXEN    2
`define SWFC_FC_TXEN    1
`define SWFC_FC_MAN     0

`define SWFC_CMD_BUSY   31
`define SWFC_CMD_DIR    30
`define SWFC_IDX_W      16

`define SWFC_DATA_RST   32'h0000_0000
`define SWFC_STRAP_WAIT 2'h3

`endif

// ==== verilog/swfc_pkg.sv ====
// Types shared by the port 0 flow control and fabric window block.
// Assumes swfc_defines.svh is on the include path.
`include "swfc_defines.svh"

package swfc_pkg;

    typedef enum {FAB_IDLE, FAB_WAIT} swfc_fab_state_t;

    typedef struct packed {
        logic fifo_coupling;
        logic backpressure;
        logic rx_pause;
        logic tx_pause;
        logic manual;
    } swfc_fc_cfg_t;

    typedef struct packed {
        logic                    valid;
        logic                    wr;
        logic [`SWFC_IDX_W-1:0]  index;
        logic [31:0]             wdata;
    } swfc_fab_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } swfc_fab_rsp_t;

endpackage : swfc_pkg

// ==== verilog/swfc_port0_regs.sv ====
// APB register slice: port 0 flow control and the indirect fabric window.
// Assumes fabric and port status inputs share sys_clk; straps are pins.
`timescale 1ns/1ps
`include "swfc_defines.svh"

module swfc_port0_regs
    import swfc_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          backpressure_strap,
    input  wire logic          duplex_pause_strap,
    input  wire logic          manual_select_strap,
    input  wire logic          an_enable,
    input  wire logic          an_rx_pause,
    input  wire logic          an_tx_pause,
    input  wire logic          port_half_duplex,
    input  wire logic          mac_rx_fifo_high,
    input  wire logic          sw_rx_fifo_high,
    output logic               sw_tx_hold,
    output logic               mac_tx_hold,
    output logic               backpressure_gen,
    output logic               rx_pause_active,
    output logic               tx_pause_active,
    output swfc_fab_req_t      fab_req,
    input  wire swfc_fab_rsp_t fab_rsp
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    //--------------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------------
    logic setup_rd;
    logic acc_wr;
    logic hit_fc;
    logic hit_data;
    logic hit_cmd;

    assign hit_fc   = (paddr == `SWFC_FC_OFS);
    assign hit_data = (paddr == `SWFC_DATA_OFS);
    assign hit_cmd  = (paddr == `SWFC_CMD_OFS);
    assign setup_rd = psel && !penable;
    assign acc_wr   = psel && penable && pwrite;
    assign pready   = psel && penable;

    //--------------------------------------------------------------------
    // Strap capture
    //--------------------------------------------------------------------
    // Straps pass three flops; after a three-cycle wait the value is taken once the last two agree.
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    logic [2:0] strap_s3_q;
    logic [1:0] strap_cnt_q;
    logic [1:0] strap_cnt_d;
    logic       strap_pend_q;
    logic       strap_pend_d;
    logic       strap_load;

    always_comb begin
        strap_cnt_d  = strap_cnt_q;
        strap_pend_d = strap_pend_q;
        strap_load   = 1'b0;
        if (strap_pend_q) begin
            if (strap_cnt_q != `SWFC_STRAP_WAIT) begin
                strap_cnt_d = strap_cnt_q + 2'h1;
            end else if (strap_s2_q == strap_s3_q) begin
                strap_load   = 1'b1;
                strap_pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_s1_q   <= 3'h0;
            strap_s2_q   <= 3'h0;
            strap_s3_q   <= 3'h0;
            strap_cnt_q  <= 2'h0;
            strap_pend_q <= 1'b1;
        end else begin
            strap_s1_q   <= {backpressure_strap, duplex_pause_strap, manual_select_strap};
            strap_s2_q   <= strap_s1_q;
            strap_s3_q   <= strap_s2_q;
            strap_cnt_q  <= strap_cnt_d;
            strap_pend_q <= strap_pend_d;
        end
    end

    //--------------------------------------------------------------------
    // Flow control configuration
    //--------------------------------------------------------------------
    swfc_fc_cfg_t cfg_q;
    swfc_fc_cfg_t cfg_d;

    always_comb begin
        cfg_d = cfg_q;
        if (strap_load) begin
            cfg_d.backpressure = strap_s3_q[2];
            cfg_d.rx_pause     = strap_s3_q[1];
            cfg_d.tx_pause     = strap_s3_q[1];
            cfg_d.manual       = strap_s3_q[0];
        end
        if (acc_wr && hit_fc) begin
            // Status and reserved bits are simply not stored.
            cfg_d.fifo_coupling = pwdata[`SWFC_FC_COUPLE];
            cfg_d.backpressure  = pwdata[`SWFC_FC_BP];
            cfg_d.rx_pause      = pwdata[`SWFC_FC_RXEN];
            cfg_d.tx_pause      = pwdata[`SWFC_FC_TXEN];
            cfg_d.manual        = pwdata[`SWFC_FC_MAN];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    //--------------------------------------------------------------------
    // Effective flow control
    //--------------------------------------------------------------------
    // Negotiated pause bits are only read here, never written back.
    logic use_regs;
    logic eff_rx;
    logic eff_tx;
    logic dup_q;

    assign use_regs = cfg_q.manual || !an_enable;
    assign eff_rx   = use_regs ? cfg_q.rx_pause : an_rx_pause;
    assign eff_tx   = use_regs ? cfg_q.tx_pause : an_tx_pause;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dup_q            <= 1'b0;
            rx_pause_active  <= 1'b0;
            tx_pause_active  <= 1'b0;
            backpressure_gen <= 1'b0;
            sw_tx_hold       <= 1'b0;
            mac_tx_hold      <= 1'b0;
        end else begin
            dup_q            <= port_half_duplex;
            rx_pause_active  <= eff_rx && !port_half_duplex;
            tx_pause_active  <= eff_tx && !port_half_duplex;
            backpressure_gen <= cfg_q.backpressure && port_half_duplex;
            sw_tx_hold       <= cfg_q.fifo_coupling && mac_rx_fifo_high;
            mac_tx_hold      <= cfg_q.fifo_coupling && sw_rx_fifo_high;
        end
    end

    property p_couple;
        cfg_q.fifo_coupling && mac_rx_fifo_high |=> sw_tx_hold;
    endproperty
    a_couple: assert property (p_couple) else $error("coupling hold missing");

    property p_no_bp;
        !cfg_q.backpressure |=> !backpressure_gen;
    endproperty
    a_no_bp: assert property (p_no_bp) else $error("backpressure while disabled");

    property p_man_rx;
        cfg_q.manual && cfg_q.rx_pause && !port_half_duplex |=> rx_pause_active;
    endproperty
    a_man_rx: assert property (p_man_rx) else $error("manual rx pause not active");

    property p_man_tx;
        use_regs && !cfg_q.tx_pause |=> !tx_pause_active;
    endproperty
    a_man_tx: assert property (p_man_tx) else $error("tx pause active while disabled");

    property p_auto_tx;
        !cfg_q.manual && an_enable && !port_half_duplex
            |-> ##1 tx_pause_active == $past(an_tx_pause);
    endproperty
    a_auto_tx: assert property (p_auto_tx) else $error("negotiated tx pause ignored");

    //--------------------------------------------------------------------
    // Indirect fabric access
    //--------------------------------------------------------------------
    swfc_fab_state_t          st_q;
    swfc_fab_state_t          st_d;
    logic                     busy_q;
    logic                     busy_d;
    logic                     dir_q;
    logic                     dir_d;
    logic [`SWFC_IDX_W-1:0]   idx_q;
    logic [`SWFC_IDX_W-1:0]   idx_d;
    logic [31:0]              data_q;
    logic [31:0]              data_d;
    logic [31:0]              fab_rd_q;
    logic [31:0]              fab_rd_d;

    always_comb begin
        st_d     = st_q;
        busy_d   = busy_q;
        dir_d    = dir_q;
        idx_d    = idx_q;
        data_d   = data_q;
        fab_rd_d = fab_rd_q;
        // Writes are ignored while busy so the request stays stable.
        if (acc_wr && !busy_q) begin
            if (hit_cmd) begin
                busy_d = pwdata[`SWFC_CMD_BUSY];
                dir_d  = pwdata[`SWFC_CMD_DIR];
                idx_d  = pwdata[`SWFC_IDX_W-1:0];
            end
            if (hit_data) begin
                data_d = pwdata;
            end
        end
        unique case (st_q)
            FAB_IDLE: begin
                if (busy_q) begin
                    st_d = FAB_WAIT;
                end
            end
            FAB_WAIT: begin
                if (fab_rsp.ack) begin
                    st_d   = FAB_IDLE;
                    busy_d = 1'b0;
                    if (dir_q) begin
                        fab_rd_d = fab_rsp.rdata;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q     <= FAB_IDLE;
            busy_q   <= 1'b0;
            dir_q    <= 1'b0;
            idx_q    <= '0;
            data_q   <= `SWFC_DATA_RST;
            fab_rd_q <= `SWFC_DATA_RST;
        end else begin
            st_q     <= st_d;
            busy_q   <= busy_d;
            dir_q    <= dir_d;
            idx_q    <= idx_d;
            data_q   <= data_d;
            fab_rd_q <= fab_rd_d;
        end
    end

    assign fab_req.valid = (st_q == FAB_WAIT);
    assign fab_req.wr    = !dir_q;
    assign fab_req.index = idx_q;
    assign fab_req.wdata = data_q;

    property p_busy_clr;
        st_q == FAB_WAIT && fab_rsp.ack |=> !busy_q ##1 !fab_req.valid;
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy did not self-clear");

    property p_dir;
        fab_req.valid |-> (fab_req.wr == !dir_q) && busy_q;
    endproperty
    a_dir: assert property (p_dir) else $error("fabric direction wrong");

    //--------------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------------
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic        err_q;
    logic        err_d;

    always_comb begin
        rd_d  = rd_q;
        err_d = err_q;
        if (setup_rd || (psel && !penable)) begin
            rd_d  = 32'h0000_0000;
            err_d = !(hit_fc || hit_data || hit_cmd);
            if (!pwrite && hit_fc) begin
                rd_d[`SWFC_FC_COUPLE] = cfg_q.fifo_coupling;
                rd_d[`SWFC_FC_BP]     = cfg_q.backpressure;
                rd_d[`SWFC_FC_DUP]    = dup_q;
                rd_d[`SWFC_FC_CRX]    = rx_pause_active;
                rd_d[`SWFC_FC_CTX]    = tx_pause_active;
                rd_d[`SWFC_FC_RXEN]   = cfg_q.rx_pause;
                rd_d[`SWFC_FC_TXEN]   = cfg_q.tx_pause;
                rd_d[`SWFC_FC_MAN]    = cfg_q.manual;
            end
            if (!pwrite && hit_data) begin
                rd_d = dir_q ? fab_rd_q : data_q;
            end
            if (!pwrite && hit_cmd) begin
                rd_d[`SWFC_CMD_BUSY]     = busy_q;
                rd_d[`SWFC_CMD_DIR]      = dir_q;
                rd_d[`SWFC_IDX_W-1:0]    = idx_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_q  <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rd_q  <= rd_d;
            err_q <= err_d;
        end
    end

    assign prdata  = rd_q;
    assign pslverr = err_q && pready;

    property p_dup_read;
        setup_rd && !pwrite && hit_fc |=> prdata[`SWFC_FC_DUP] == $past(dup_q);
    endproperty
    a_dup_read: assert property (p_dup_read) else $error("duplex readback wrong");

    property p_data_rd;
        setup_rd && !pwrite && hit_data && dir_q |=> prdata == $past(fab_rd_q);
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("fabric read data wrong");

    property p_resv;
        setup_rd && !pwrite && hit_fc |=> prdata[31:8] == 24'h00_0000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");

endmodule : swfc_port0_regs
